// ==== design/fpsr_cfg.svh ====
// Offsets, field positions, reset values and the rule summary
// How it works
// - Context address keeps bits 31:3 writable; bits 2:0 read zero.
// - Compare result sets N Z C V to 0110, 1000, 0010 or 0011.
// - Status bit 26 selects IEEE or alternative half-precision format.
// - Status bit 25 set returns default NaN for any NaN input.
// - Status bit 24 set enables flush-to-zero, clear means IEEE compliant.
// - Bits 23:22 select rounding: nearest, plus, minus, toward zero.
// - Six sticky exception flags stay set until software writes zero or a status read clears them.
// - Default status holds writable copies of bits 26, 25, 24, 23:22.
// - Unit leaves reset disabled; software enables it before use.
// - Context address and default status are reachable only when privileged.
// - Exception flags drive the interrupt, each gated by its own mask.
// - In one variant no masks exist and inexact never raises interrupt.
// - With lazy saving, a status read clears flags and, while lazy preservation is active, forces context save.
// - With automatic saving only, a status read clears the live flags.
// - Lazy preservation active means frame allocated, saving deferred.
`ifndef FPSR_CFG_SVH
`define FPSR_CFG_SVH
`define FPSR_OFF_CTX_ADDR 4'h8
`define FPSR_OFF_DEF_STAT 4'hC
`define FPSR_CTX_ADDR_MASK 32'hFFFF_FFF8
`define FPSR_DEF_STAT_MASK 32'h07C0_0000
`define FPSR_STAT_MASK 32'hF7C0_009F
`define FPSR_FLAG_MASK 8'h9F
`define FPSR_RESET 32'h0000_0000
`define FPSR_BIT_HALF 26
`define FPSR_BIT_DNAN 25
`define FPSR_BIT_FTZ 24
`define FPSR_RND_HI 23
`define FPSR_RND_LO 22
`define FPSR_BIT_INEXACT 4
`define FPSR_CPA_LO 20
`define FPSR_CPA_HI 23
`endif

// ==== design/fpsr_pkg.sv ====
// Types shared by the status and context register bank
package fpsr_pkg;
  typedef enum logic [1:0] {
    FPSR_CMP_EQ = 2'h0,
    FPSR_CMP_LT = 2'h1,
    FPSR_CMP_GT = 2'h3,
    FPSR_CMP_UN = 2'h2
  } fpsr_cmp_type;
  typedef enum logic [1:0] {
    FPSR_RND_NEAREST = 2'h0,
    FPSR_RND_PLUS = 2'h1,
    FPSR_RND_MINUS = 2'h2,
    FPSR_RND_ZERO = 2'h3
  } fpsr_rnd_type;
  typedef enum logic [1:0] {
    FPSR_IDLE = 2'h0,
    FPSR_SAVE = 2'h1,
    FPSR_DONE = 2'h3
  } fpsr_save_type;
endpackage : fpsr_pkg

// ==== design/fpsr_irq.sv ====
// Masked interrupt combining of the sticky exception flags
`timescale 1ns/1ps
`include "fpsr_cfg.svh"
module fpsr_irq #(
  parameter bit NO_MASK_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] flags,
  input wire logic [7:0] mask_en,
  output logic irq
);
  logic [7:0] gate;
  logic [7:0] hit;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_gate
      if (NO_MASK_VARIANT) begin : g_nomask
        // Inexact never reaches the controller here
        assign gate[i] = (i != `FPSR_BIT_INEXACT);
      end else begin : g_mask
        assign gate[i] = mask_en[i];
      end
    end
  endgenerate
  assign hit = flags & gate & `FPSR_FLAG_MASK;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |hit;
    end
  end
endmodule : fpsr_irq

// ==== design/fpsr_regs.sv ====
// Floating-point status, default status and context address registers
`timescale 1ns/1ps
`include "fpsr_cfg.svh"
module fpsr_regs #(
  parameter bit NO_MASK_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic priv,
  input wire logic [3:0] sys_addr,
  input wire logic sys_wr,
  input wire logic sys_rd,
  input wire logic [31:0] sys_wdata,
  output logic [31:0] sys_rdata,
  output logic sys_fault,
  input wire logic stat_wr,
  input wire logic stat_rd,
  input wire logic [31:0] stat_wdata,
  output logic [31:0] stat_rdata,
  input wire logic ctx_new,
  input wire logic cmp_valid,
  input wire logic [1:0] cmp_result,
  input wire logic exc_valid,
  input wire logic [7:0] exc_flags,
  input wire logic [31:0] coprocessor_access_control,
  input wire logic lazy_save_enable,
  input wire logic auto_save_enable,
  input wire logic lazy_active,
  input wire logic [7:0] flag_mask_en,
  output logic fpu_enabled,
  output logic save_req,
  input wire logic save_done,
  output logic alt_half_precision,
  output logic default_nan_mode,
  output logic flush_to_zero,
  output logic [1:0] rounding_select,
  output logic irq
);
  logic [31:0] fp_context_address_r;
  logic [31:0] fp_default_status_r;
  logic [31:0] fp_status_control_r;
  logic [3:0] nzcv_nxt;
  logic [7:0] flags_nxt;
  logic sys_ok;
  logic read_clears;
  fpsr_pkg::fpsr_save_type save_r;

  function automatic logic [3:0] fpsr_cmp_flags(input logic [1:0] res);
    case (fpsr_pkg::fpsr_cmp_type'(res))
      fpsr_pkg::FPSR_CMP_EQ: fpsr_cmp_flags = 4'h6;
      fpsr_pkg::FPSR_CMP_LT: fpsr_cmp_flags = 4'h8;
      fpsr_pkg::FPSR_CMP_GT: fpsr_cmp_flags = 4'h2;
      default: fpsr_cmp_flags = 4'h3;
    endcase
  endfunction : fpsr_cmp_flags

  // Privileged access only to the mapped registers
  assign sys_ok = priv;
  // Status read clears live flags when any context saving is on
  assign read_clears = stat_rd & (lazy_save_enable | auto_save_enable);

  // Both access fields must be full or privileged before use
  assign fpu_enabled =
    coprocessor_access_control[`FPSR_CPA_LO] &&
    coprocessor_access_control[`FPSR_CPA_LO + 2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_context_address_r <= `FPSR_RESET;
    end else if (ce && sys_wr && sys_ok &&
                 sys_addr == `FPSR_OFF_CTX_ADDR) begin
      fp_context_address_r <= sys_wdata & `FPSR_CTX_ADDR_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_default_status_r <= `FPSR_RESET;
    end else if (ce && sys_wr && sys_ok &&
                 sys_addr == `FPSR_OFF_DEF_STAT) begin
      fp_default_status_r <= sys_wdata & `FPSR_DEF_STAT_MASK;
    end
  end

  always_comb begin
    nzcv_nxt = fp_status_control_r[31:28];
    if (stat_wr) begin
      nzcv_nxt = stat_wdata[31:28];
    end
    if (cmp_valid) begin
      nzcv_nxt = fpsr_cmp_flags(cmp_result);
    end
  end

  always_comb begin
    flags_nxt = fp_status_control_r[7:0];
    if (stat_wr) begin
      flags_nxt = stat_wdata[7:0];
    end else if (read_clears) begin
      flags_nxt = 8'h00;
    end
    if (exc_valid) begin
      // Hardware set wins over a clear in the same cycle
      flags_nxt = flags_nxt | exc_flags;
    end
    flags_nxt = flags_nxt & `FPSR_FLAG_MASK;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_status_control_r <= `FPSR_RESET;
    end else if (ce) begin
      fp_status_control_r[31:28] <= nzcv_nxt;
      fp_status_control_r[7:0] <= flags_nxt;
      if (ctx_new) begin
        // New context takes the default mode bits
        fp_status_control_r[26:22] <= fp_default_status_r[26:22];
      end else if (stat_wr) begin
        fp_status_control_r[26:22] <= stat_wdata[26:22];
      end
    end
  end

  // Deferred save handshake when lazy preservation is active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      save_r <= fpsr_pkg::FPSR_IDLE;
    end else if (ce) begin
      case (save_r)
        fpsr_pkg::FPSR_IDLE: begin
          if (stat_rd && lazy_save_enable && lazy_active) begin
            save_r <= fpsr_pkg::FPSR_SAVE;
          end
        end
        fpsr_pkg::FPSR_SAVE: begin
          if (save_done) begin
            save_r <= fpsr_pkg::FPSR_DONE;
          end
        end
        default: save_r <= fpsr_pkg::FPSR_IDLE;
      endcase
    end
  end
  assign save_req = (save_r == fpsr_pkg::FPSR_SAVE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_rdata <= 32'h0000_0000;
      sys_fault <= 1'b0;
    end else if (ce) begin
      sys_fault <= (sys_rd | sys_wr) & ~sys_ok;
      if (!sys_rd || !sys_ok) begin
        sys_rdata <= 32'h0000_0000;
      end else if (sys_addr == `FPSR_OFF_CTX_ADDR) begin
        sys_rdata <= fp_context_address_r;
      end else if (sys_addr == `FPSR_OFF_DEF_STAT) begin
        sys_rdata <= fp_default_status_r;
      end else begin
        sys_rdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_rdata <= 32'h0000_0000;
    end else if (ce && stat_rd) begin
      stat_rdata <= fp_status_control_r & `FPSR_STAT_MASK;
    end
  end

  assign alt_half_precision = fp_status_control_r[`FPSR_BIT_HALF];
  assign default_nan_mode = fp_status_control_r[`FPSR_BIT_DNAN];
  assign flush_to_zero = fp_status_control_r[`FPSR_BIT_FTZ];
  assign rounding_select =
    fp_status_control_r[`FPSR_RND_HI:`FPSR_RND_LO];

  fpsr_irq #(
    .NO_MASK_VARIANT(NO_MASK_VARIANT)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .flags(fp_status_control_r[7:0]),
    .mask_en(flag_mask_en),
    .irq(irq)
  );
endmodule : fpsr_regs

// ==== sim/fpsr_regs_chk.sv ====
// Port-level assertions for the status and context register bank
`timescale 1ns/1ps
module fpsr_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic priv,
  input wire logic sys_wr,
  input wire logic sys_rd,
  input wire logic stat_rd,
  input wire logic stat_wr,
  input wire logic [3:0] sys_addr,
  input wire logic [31:0] sys_rdata,
  input wire logic [31:0] coprocessor_access_control,
  input wire logic sys_fault,
  input wire logic irq,
  input wire logic save_req,
  input wire logic fpu_enabled,
  input wire logic lazy_save_enable,
  input wire logic lazy_active,
  input wire logic exc_valid,
  input wire logic [7:0] exc_flags,
  input wire logic [7:0] flag_mask_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_low; sys_rd && ce |=> sys_rdata[2:0] == 3'h0; endproperty
  a_low: assert property (p_low) else $error("low bits");
  property p_flt; sys_wr && !priv && ce |=> sys_fault; endproperty
  a_flt: assert property (p_flt) else $error("no fault");
  property p_dny; sys_rd && !priv && ce |=> sys_rdata == 32'h0; endproperty
  a_dny: assert property (p_dny) else $error("denied data");
  property p_def;
    sys_rd && priv && ce && sys_addr == 4'hC
      |=> (sys_rdata & 32'hF83F_FFFF) == 32'h0;
  endproperty
  a_def: assert property (p_def) else $error("default bits");
  property p_off;
    coprocessor_access_control[23:20] == 4'h0 |-> !fpu_enabled;
  endproperty
  a_off: assert property (p_off) else $error("unit on");
  property p_irq;
    exc_valid && ce && (exc_flags & flag_mask_en & 8'h9F) != 8'h0
      ##1 ce && !stat_wr && !stat_rd |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq late");
  property p_msk; (ce && flag_mask_en == 8'h0) [*2] |=> !irq; endproperty
  a_msk: assert property (p_msk) else $error("masked irq");
  property p_lzy;
    stat_rd && ce && lazy_save_enable && lazy_active |=> save_req;
  endproperty
  a_lzy: assert property (p_lzy) else $error("no save");
endmodule : fpsr_chk
bind fpsr_regs fpsr_chk chk_u (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .priv(priv),
  .sys_wr(sys_wr),
  .sys_rd(sys_rd),
  .stat_rd(stat_rd),
  .stat_wr(stat_wr),
  .sys_addr(sys_addr),
  .sys_rdata(sys_rdata),
  .coprocessor_access_control(coprocessor_access_control),
  .sys_fault(sys_fault),
  .irq(irq),
  .save_req(save_req),
  .fpu_enabled(fpu_enabled),
  .lazy_save_enable(lazy_save_enable),
  .lazy_active(lazy_active),
  .exc_valid(exc_valid),
  .exc_flags(exc_flags),
  .flag_mask_en(flag_mask_en)
);

// ==== sim/fpsr_core_mdl.sv ====
// Core-side model answering deferred context saves
`timescale 1ns/1ps
module fpsr_core_mdl (
  input wire logic clk, rst, save_req,
  input wire logic [3:0] dly,
  output logic save_done
);
  logic [3:0] n_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_r <= 4'h0;
      save_done <= 1'b0;
    end else begin
      save_done <= save_req && !save_done && n_r == dly;
      n_r <= (save_req && !save_done) ? n_r + 4'h1 : 4'h0;
    end
  end
endmodule : fpsr_core_mdl

// ==== sim/fpsr_regs_tb.sv ====
// Self-checking bench for the status and context register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", n, e, a); end end
module fpsr_regs_tb;
  logic clk, rst, ce, priv, sys_wr, sys_rd, stat_wr, stat_rd, ctx_new;
  logic cmp_valid, exc_valid, lazy_save_enable, auto_save_enable;
  logic lazy_active, fpu_enabled, save_req, save_done, irq, sys_fault;
  logic alt_half_precision, default_nan_mode, flush_to_zero;
  logic [1:0] cmp_result, rounding_select;
  logic [3:0] sys_addr, dly;
  logic [7:0] exc_flags, flag_mask_en, m_flags;
  logic [31:0] sys_wdata, sys_rdata, stat_wdata, stat_rdata, v, rnd, m_ctx;
  logic [31:0] coprocessor_access_control;
  logic [3:0] nzcv [4] = '{4'h6, 4'h8, 4'h3, 4'h2};
  int n_mismatch = 0, num_checks = 0;
  fpsr_regs dut_u (.*);
  fpsr_core_mdl core_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic sys(logic w, logic [3:0] a, logic [31:0] d);
    cyc(1);
    {sys_wr, sys_rd, sys_addr, sys_wdata} = {w, !w, a, d};
    cyc(1);
    {sys_wr, sys_rd} = 2'b00;
  endtask : sys
  task automatic stat(logic w, logic [31:0] d);
    cyc(1);
    {stat_wr, stat_rd, stat_wdata} = {w, !w, d};
    cyc(1);
    {stat_wr, stat_rd} = 2'b00;
  endtask : stat
  task automatic exc(logic [7:0] f);
    cyc(1);
    {exc_valid, exc_flags} = {1'b1, f};
    cyc(1);
    exc_valid = 1'b0;
    m_flags = m_flags | f;
  endtask : exc
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    {ce, priv, rst, dly, rnd, m_ctx, m_flags} = {3'h7, 4'h3, 32'h46, 40'h0};
    {sys_wr, sys_rd, stat_wr, stat_rd, ctx_new, cmp_valid, exc_valid} = '0;
    {lazy_save_enable, auto_save_enable, lazy_active, sys_addr} = '0;
    {sys_wdata, stat_wdata, cmp_result, exc_flags, flag_mask_en} = '0;
    coprocessor_access_control = 32'h0;
    cyc(12);
    rst = 1'b0;
    `CHK("fpu_off", 1'b0, fpu_enabled)
    sys(0, 4'h8, 32'h0);
    `CHK("ctx_rst", 32'h0, sys_rdata)
    rnd = lfsr(rnd);
    sys(1, 4'h8, rnd);
    m_ctx = rnd & 32'hFFFF_FFF8;
    sys(0, 4'h8, 32'h0);
    `CHK("ctx", m_ctx, sys_rdata)
    priv = 1'b0;
    sys(1, 4'h8, 32'h0);
    `CHK("fault", 1'b1, sys_fault)
    priv = 1'b1;
    sys(0, 4'h8, 32'h0);
    `CHK("ctx_kept", m_ctx, sys_rdata)
    ce = 1'b0;
    sys(1, 4'h8, 32'h0);
    ce = 1'b1;
    sys(0, 4'h8, 32'h0);
    `CHK("ctx_frozen", m_ctx, sys_rdata)
    sys(0, 4'h4, 32'h0);
    `CHK("unmapped", 32'h0, sys_rdata)
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      v = {5'h0, rnd[26:24], k[1:0], 22'h0};
      sys(1, 4'hC, v);
      sys(0, 4'hC, 32'h0);
      `CHK("def", v, sys_rdata)
      cyc(1);
      ctx_new = 1'b1;
      cyc(1);
      ctx_new = 1'b0;
      `CHK("mode", v[26:22], {alt_half_precision, default_nan_mode,
        flush_to_zero, rounding_select})
      cyc(1);
      {cmp_valid, cmp_result} = {1'b1, k[1:0]};
      cyc(1);
      cmp_valid = 1'b0;
      stat(0, 32'h0);
      `CHK("nzcv", nzcv[k], stat_rdata[31:28])
    end
    $display("mode test done");
    flag_mask_en = 8'hFF;
    exc(8'h01);
    exc(8'h02);
    stat(0, 32'h0);
    `CHK("flags", m_flags, stat_rdata[7:0])
    `CHK("irq", 1'b1, irq)
    stat(1, stat_rdata & ~32'h8F);
    m_flags = 8'h0;
    cyc(1);
    `CHK("irq_drop", 1'b0, irq)
    flag_mask_en = 8'h0;
    exc(8'h10);
    cyc(2);
    `CHK("irq_mask", 1'b0, irq)
    auto_save_enable = 1'b1;
    stat(0, 32'h0);
    `CHK("auto_rd", m_flags, stat_rdata[7:0])
    stat(0, 32'h0);
    `CHK("auto_clr", 8'h0, stat_rdata[7:0])
    auto_save_enable = 1'b0;
    $display("flag test done");
    {lazy_save_enable, lazy_active} = 2'b11;
    exc(8'h04);
    stat(0, 32'h0);
    `CHK("save_req", 1'b1, save_req)
    for (int i = 0; i < 20 && save_req; i++) cyc(1);
    `CHK("save_end", 1'b0, save_req)
    {lazy_save_enable, lazy_active} = 2'b00;
    stat(0, 32'h0);
    `CHK("lazy_clr", 8'h0, stat_rdata[7:0])
    coprocessor_access_control = 32'h0010_0000;
    cyc(1);
    `CHK("fpu_half", 1'b0, fpu_enabled)
    coprocessor_access_control = 32'h00F0_0000;
    cyc(1);
    `CHK("fpu_on", 1'b1, fpu_enabled)
    $display("save test done");
    close_out;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule : fpsr_regs_tb
